//--- src/dcwb_write_buffer.sv
// level_one_data_cache write buffer with cpu stall generation
// assumes the cache tags supply the hit flag and lower memory gives ready
`timescale 1ns/1ps
module dcwb_write_buffer (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire dcwb_pkg::dcwb_cpu_st_t cpu_st_in,
   input wire dcwb_pkg::dcwb_cpu_ld_t cpu_ld_in,
   output logic cpu_stall_out,
   output logic cache_wr_out,
   output logic miss_busy_out,
   output logic miss_done_out,
   output logic mem_valid_out,
   input wire logic mem_ready_in,
   output dcwb_pkg::dcwb_store_t mem_store_out,
   output logic [2:0] fill_out
);
   localparam int SW = $bits(dcwb_pkg::dcwb_store_t);

   dcwb_pkg::dcwb_state_t state_r, state_nxt;
   logic [3:0] miss_cnt_r, miss_cnt_nxt;
   logic [1:0] age_r, age_nxt;
   logic pair_r, pair_nxt;
   logic done_r, done_nxt;
   logic fifo_wr_ready, fifo_rd_valid, fifo_pop, st_miss;
   logic [SW-1:0] fifo_rd_data;
   logic [2:0] fifo_cnt;

   ////////////////////////////////////////////////////////////////////////
   // queue of pending stores
   assign st_miss = cpu_st_in.valid && !cpu_st_in.hit;
   dcwb_fifo #(
      .WIDTH(SW),
      .DEPTH(dcwb_pkg::WB_DEPTH)
   ) u_fifo (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .clk_en_in(clk_en_in),
      .wr_valid_in(st_miss),
      .wr_ready_out(fifo_wr_ready),
      .wr_data_in(cpu_st_in.st),
      .rd_valid_out(fifo_rd_valid),
      .rd_ready_in(fifo_pop),
      .rd_data_out(fifo_rd_data),
      .count_out(fifo_cnt)
   );

   ////////////////////////////////////////////////////////////////////////
   // retire pacing: head entry leaves once it has aged one cycle
   always_comb begin
      fifo_pop = fifo_rd_valid && mem_ready_in &&
         (age_r >= dcwb_pkg::RETIRE_CNT_W2 - 2'h1);
      age_nxt = age_r;
      if (fifo_pop || !fifo_rd_valid) begin
         age_nxt = '0;
      end else if (age_r < dcwb_pkg::RETIRE_CNT_W2) begin
         age_nxt = age_r + 2'h1;
      end
   end

   // head of queue goes out in order
   assign mem_valid_out = fifo_rd_valid &&
      (age_r >= dcwb_pkg::RETIRE_CNT_W2 - 2'h1);
   assign mem_store_out = fifo_rd_data;
   assign fill_out = fifo_cnt;
   assign cache_wr_out = cpu_st_in.valid && cpu_st_in.hit;

   ////////////////////////////////////////////////////////////////////////
   // load miss sequencer: drain, then fixed miss latency
   always_comb begin
      state_nxt = state_r;
      miss_cnt_nxt = miss_cnt_r;
      pair_nxt = pair_r;
      done_nxt = 1'b0;
      case (state_r)
         dcwb_pkg::ST_IDLE: begin
            if (cpu_ld_in.valid) begin
               pair_nxt = cpu_ld_in.pair;
               state_nxt = dcwb_pkg::ST_DRAIN;
            end
         end
         dcwb_pkg::ST_DRAIN: begin
            // drain cycles stretch the stall
            if (!fifo_rd_valid || (fifo_cnt == 3'h1 && fifo_pop)) begin
               state_nxt = dcwb_pkg::ST_MISS;
               miss_cnt_nxt = pair_r ? dcwb_pkg::PAIR_CNT_W4
                  : dcwb_pkg::MISS_CNT_W4;
            end
         end
         dcwb_pkg::ST_MISS: begin
            miss_cnt_nxt = miss_cnt_r - dcwb_pkg::CNT_ONE;
            if (miss_cnt_r == dcwb_pkg::CNT_ONE) begin
               state_nxt = dcwb_pkg::ST_IDLE;
               done_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = dcwb_pkg::ST_IDLE;
         end
      endcase
   end

   // stall while full on a store miss or while a load miss is pending
   always_comb begin
      cpu_stall_out = (st_miss && !fifo_wr_ready)
         || (state_r != dcwb_pkg::ST_IDLE)
         || cpu_ld_in.valid;
      miss_busy_out = (state_r == dcwb_pkg::ST_MISS);
   end
   assign miss_done_out = done_r;

   // register sequencer state
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         state_r <= dcwb_pkg::ST_IDLE;
         miss_cnt_r <= dcwb_pkg::CNT_ZERO;
         age_r <= '0;
         pair_r <= 1'b0;
         done_r <= 1'b0;
      end else if (clk_en_in) begin
         state_r <= state_nxt;
         miss_cnt_r <= miss_cnt_nxt;
         age_r <= age_nxt;
         pair_r <= pair_nxt;
         done_r <= done_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_max_four;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      fill_out <= 3'h4;
   endproperty
   a_max_four: assert property (p_max_four)
      else $error("write buffer above four entries");

   property p_full_stall;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      (st_miss && fill_out == 3'h4) |-> cpu_stall_out;
   endproperty
   a_full_stall: assert property (p_full_stall)
      else $error("store miss on full buffer without stall");

   property p_no_stall_room;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      (st_miss && fill_out < 3'h4 && state_r == dcwb_pkg::ST_IDLE
         && !cpu_ld_in.valid) |-> !cpu_stall_out;
   endproperty
   a_no_stall_room: assert property (p_no_stall_room)
      else $error("store miss stalled with room left");

   property p_drained;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      (state_r == dcwb_pkg::ST_MISS) |-> fill_out == 3'h0;
   endproperty
   a_drained: assert property (p_drained)
      else $error("miss serviced with pending stores");

   property p_hit_no_entry;
      @(posedge core_clk_in) disable iff (sys_rst_in || !clk_en_in)
      (cpu_st_in.valid && cpu_st_in.hit && !fifo_pop) |=>
         fill_out == $past(fill_out);
   endproperty
   a_hit_no_entry: assert property (p_hit_no_entry)
      else $error("store hit entered the buffer");

   property p_single_miss;
      @(posedge core_clk_in) disable iff (sys_rst_in || !clk_en_in)
      ($rose(state_r == dcwb_pkg::ST_MISS) && !pair_r) |->
         miss_busy_out [*4] ##1 miss_done_out;
   endproperty
   a_single_miss: assert property (p_single_miss)
      else $error("single miss not four cycles");

   property p_pair_miss;
      @(posedge core_clk_in) disable iff (sys_rst_in || !clk_en_in)
      ($rose(state_r == dcwb_pkg::ST_MISS) && pair_r) |->
         miss_busy_out [*7] ##1 miss_done_out;
   endproperty
   a_pair_miss: assert property (p_pair_miss)
      else $error("paired miss not seven cycles");

   property p_retire_bound;
      @(posedge core_clk_in) disable iff (sys_rst_in || !clk_en_in)
      (fifo_rd_valid && mem_ready_in && !fifo_pop) |=>
         (fifo_pop || !mem_ready_in);
   endproperty
   a_retire_bound: assert property (p_retire_bound)
      else $error("entry retire beyond two cycles");

   property p_drain_stall;
      @(posedge core_clk_in) disable iff (sys_rst_in || !clk_en_in)
      (state_r == dcwb_pkg::ST_DRAIN && fill_out > 3'h1) |=>
         (state_r == dcwb_pkg::ST_DRAIN && cpu_stall_out);
   endproperty
   a_drain_stall: assert property (p_drain_stall)
      else $error("drain ended early with stores pending");

   property p_order;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      (mem_valid_out && !mem_ready_in) |=>
         (mem_valid_out && mem_store_out == $past(mem_store_out));
   endproperty
   a_order: assert property (p_order)
      else $error("offered store changed before accept");
endmodule : dcwb_write_buffer

//--- common/dcwb_pkg.sv
// package for the data cache write buffer block
// assumes a single clock domain and synchronous active-high reset
package dcwb_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int WB_DEPTH = 4;
   localparam int LINE_BYTES = 32;
   localparam int CLK_MHZ = 40;
   localparam int CLK_PERIOD_NS = 25;
   // load miss stall without drain, in cycles
   localparam int MISS_STALL_CYC = 4;
   // two overlapped load misses together
   localparam int PAIR_MISS_STALL_CYC = 7;
   // longest retire of one entry
   localparam int RETIRE_CYC = 2;
   localparam logic [3:0] MISS_CNT_W4 = 4'h4;
   localparam logic [3:0] PAIR_CNT_W4 = 4'h7;
   localparam logic [1:0] RETIRE_CNT_W2 = 2'h2;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [3:0] CNT_ZERO = 4'h0;

   // one pending store
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [BE_W-1:0] be;
   } dcwb_store_t;

   // cpu store request
   typedef struct packed {
      logic valid;
      logic hit;
      dcwb_store_t st;
   } dcwb_cpu_st_t;

   // cpu load miss request
   typedef struct packed {
      logic valid;
      logic pair;
   } dcwb_cpu_ld_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DRAIN,
      ST_MISS
   } dcwb_state_t;
endpackage : dcwb_pkg

//--- src/dcwb_fifo.sv
// in-order fifo for pending stores
// assumes one clock, synchronous reset, clock enable freezing all state
`timescale 1ns/1ps
module dcwb_fifo #(
   parameter int WIDTH = 68,
   parameter int DEPTH = 4
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   input wire logic [WIDTH-1:0] wr_data_in,
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   output logic [WIDTH-1:0] rd_data_out,
   output logic [$clog2(DEPTH):0] count_out
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [PW:0] cnt_r, cnt_nxt;
   logic push, pop;

   // handshakes and pointer update
   always_comb begin
      push = wr_valid_in && wr_ready_out;
      pop = rd_valid_out && rd_ready_in;
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   assign wr_ready_out = (cnt_r != DEPTH[PW:0]);
   assign rd_valid_out = (cnt_r != '0);
   assign rd_data_out = mem_r[rp_r];
   assign count_out = cnt_r;

   // register pointers and storage
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else if (clk_en_in) begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         if (push) begin
            mem_r[wp_r] <= wr_data_in;
         end
      end
   end
endmodule : dcwb_fifo

//--- test/dcwb_mem_model.sv
// lower memory model taking retired stores from the write buffer
// assumes tb sets the pace: 0 always ready, 1 every other cycle, 2 stalled
`timescale 1ns/1ps
module dcwb_mem_model (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic [1:0] mode_in,
   input wire logic mem_valid_in,
   input wire dcwb_pkg::dcwb_store_t mem_store_in,
   output logic mem_ready_out
);
   dcwb_pkg::dcwb_store_t log_q[$];
   logic tog_r;
   ////////////////////////////////////////////////////////////////////////
   // ready pacing, slow mode alternates
   assign mem_ready_out = (mode_in == 2'h0) | ((mode_in == 2'h1) & tog_r);
   // record every accepted store in arrival order
   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         tog_r <= 1'b0;
      end else begin
         tog_r <= ~tog_r;
         if (mem_valid_in & mem_ready_out) begin
            log_q.push_back(mem_store_in);
         end
      end
   end
endmodule : dcwb_mem_model

//--- test/tb_data_cache_write_buffer.sv
// testbench for the write buffer with stall generation
// assumes lower memory is the model beside it, clk_en driven by the bench
`timescale 1ns/1ps
module tb_data_cache_write_buffer;
   logic clk, rst, stall, cwr, busy, done, mval, mrdy;
   logic cen;
   logic [1:0] mode;
   logic [2:0] fill;
   dcwb_pkg::dcwb_cpu_st_t st;
   dcwb_pkg::dcwb_cpu_ld_t ld;
   dcwb_pkg::dcwb_store_t mst;
   int n_mismatch, num_checks, ns0, ns1;
   dcwb_write_buffer dut (.core_clk_in(clk), .sys_rst_in(rst),
      .clk_en_in(cen), .cpu_st_in(st), .cpu_ld_in(ld),
      .cpu_stall_out(stall), .cache_wr_out(cwr), .miss_busy_out(busy),
      .miss_done_out(done), .mem_valid_out(mval), .mem_ready_in(mrdy),
      .mem_store_out(mst), .fill_out(fill));
   dcwb_mem_model mem (.core_clk_in(clk), .sys_rst_in(rst), .mode_in(mode),
      .mem_valid_in(mval), .mem_store_in(mst), .mem_ready_out(mrdy));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [67:0] got, input logic [67:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   function automatic dcwb_pkg::dcwb_store_t mk(input int i);
      mk = {32'h1000 + i, 32'ha0 + i, 4'(i + 1)};
   endfunction : mk
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   // store hit writes the cache, no entry
   task automatic t_hit();
      st = '{valid: 1'b1, hit: 1'b1, st: mk(9)};
      #1 chk(68'(cwr), 68'h1);
      @(posedge clk) #1;
      chk(68'(fill), 68'h0);
   endtask : t_hit
   // clock enable low freezes the queue, a store miss is not taken
   task automatic t_freeze();
      cen = 1'b0;
      st.hit = 1'b0;
      #1 chk(68'(cwr), 68'h0);
      @(posedge clk) #1 chk(68'(fill), 68'h0);
      st.valid = 1'b0;
      cen = 1'b1;
      @(posedge clk) #1 chk(68'(fill), 68'h0);
   endtask : t_freeze
   // fill to four with memory stalled, fifth stalls, then in-order drain
   task automatic t_full();
      int k;
      mode = 2'h2;
      for (int i = 0; i < 5; i++) begin
         st = '{valid: 1'b1, hit: 1'b0, st: mk(i)};
         #1 chk(68'(stall), 68'(i == 4));
         if (i < 4) @(posedge clk) #1;
      end
      chk(68'(fill), 68'h4);
      chk(68'(mval), 68'h1);
      chk(mst, mk(0));
      repeat (3) @(posedge clk) #1 chk(68'(stall), 68'h1);
      mode = 2'h0;
      k = 0;
      while (stall === 1'b1 && k < 10) begin
         @(posedge clk) #1 k++;
      end
      chk(68'(mval), 68'h0);
      chk(mst, mk(1));
      chk(68'(fill), 68'h3);
      @(posedge clk) #1 st.valid = 1'b0;
      k = 0;
      while (fill !== 3'h0 && k < 20) begin
         @(posedge clk) #1 k++;
      end
      for (int i = 0; i < 5; i++) chk(mem.log_q[i], mk(i));
   endtask : t_full
   // load miss: count busy and stall cycles up to the done pulse
   task automatic t_miss(input logic pr, input int exp, output int ns);
      int nb;
      ld = '{valid: 1'b1, pair: pr};
      #1 ns = int'(stall === 1'b1);
      nb = 0;
      for (int k = 0; k < 60 && done !== 1'b1; k++) begin
         @(posedge clk) #1 ld.valid = 1'b0;
         if (busy === 1'b1 && nb == 0) chk(68'(fill), 68'h0);
         nb += int'(busy === 1'b1);
         ns += int'(stall === 1'b1);
      end
      chk(68'(done), 68'h1);
      chk(68'(nb), 68'(exp));
      @(posedge clk) #1;
   endtask : t_miss
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #(25 * 5000) n_mismatch++;
      results();
   end
   initial begin
      n_mismatch = 0;
      num_checks = 0;
      rst = 1'b1;
      mode = 2'h0;
      cen = 1'b1;
      st = '0;
      ld = '0;
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      t_hit();
      t_freeze();
      t_full();
      t_miss(1'b0, 4, ns0);
      t_miss(1'b1, 7, ns1);
      mode = 2'h1;
      st = '{valid: 1'b1, hit: 1'b0, st: mk(5)};
      @(posedge clk) #1 st.st = mk(6);
      @(posedge clk) #1 st.valid = 1'b0;
      t_miss(1'b0, 4, ns1);
      chk(68'(ns1 > ns0), 68'h1);
      chk(mem.log_q[6], mk(6));
      results();
   end
endmodule : tb_data_cache_write_buffer
